// File: rtl/csr_top.sv
// power-up strap capture, configuration select and reference pick
// assumes select pins are clean synchronous levels from a board controller
// Function
// - the strap pin is sampled once at power-up and high makes the shared pins selects.
// - a low or floating strap makes the shared pins the i2c lines.
// - after sampling the strap pin becomes the reference clock output.
// - with strap high the two select bits pick config 0 to 3 and i2c is off.
// - with strap low i2c is on and loads i2c defaults or config 0 by stored bit 7.
// - select changes count only after 10 ms, with strap high and stored bit 7 zero.
// - after a select change the new config is loaded within 1 ms.
// - manual mode source is crystal when primary bit xor pick pin is 0, else diff.
// - the primary bit is bit 1 of primary_source_ctrl and is writable over i2c.
// - spread modulation amount is passed to the fractional dividers.
// - the pick pin acts only when the mode field upper bit is zero, glitch free.
`timescale 1ns/1ps
module csr_top #(
   parameter int unsigned SEL_QUIET_CYC = csr_pkg::SEL_QUIET_CYC,
   parameter int unsigned LOAD_CYC = csr_pkg::LOAD_CYC
) (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic refout_strap_pin_in,
   output logic refout_strap_pin_out,
   output logic refout_strap_pin_oe_n_out,
   input wire logic refclk_in,
   input wire logic cfg_pick_hi_in,
   input wire logic cfg_pick_lo_in,
   input wire logic i2c_default_load_bit_in,
   input wire logic input_pick_pin_in,
   input wire logic [1:0] switchover_mode_field_in,
   input wire csr_pkg::csr_reg_wr_t reg_wr_in,
   input wire logic [7:0] reg_rd_addr_in,
   output logic [7:0] reg_rd_data_out,
   input wire logic [csr_pkg::SPREAD_W-1:0] spread_amount_in,
   output logic [csr_pkg::SPREAD_W-1:0] fod_spread_out,
   output logic strap_done_out,
   output logic i2c_enable_out,
   output logic sel_pins_enable_out,
   output csr_pkg::csr_load_t load_out,
   output logic load_pulse_out,
   output logic loading_out,
   output csr_pkg::csr_src_t ref_src_out
);
   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {ST_STRAP, ST_BOOT, ST_RUN, ST_LOAD} csr_st_t;
   csr_st_t st;
   csr_st_t next_st;
   logic strap;
   logic next_strap;
   logic [2:0] samp;
   logic [2:0] next_samp;
   logic [31:0] tmr;
   logic [31:0] next_tmr;
   logic quiet_done;
   logic next_quiet_done;
   logic [1:0] sel_seen;
   logic [1:0] next_sel_seen;
   csr_pkg::csr_load_t load;
   csr_pkg::csr_load_t next_load;
   logic pulse;
   logic next_pulse;
   logic [7:0] prim_reg;
   logic [7:0] next_prim_reg;
   logic [7:0] rd_data;
   logic [7:0] next_rd_data;
   logic [csr_pkg::SPREAD_W-1:0] spread;
   logic [csr_pkg::SPREAD_W-1:0] next_spread;
   logic [1:0] sel_now;
   // end counts cut to the timer width on purpose
   localparam logic [31:0] QUIET_LAST = 32'(SEL_QUIET_CYC - 1);
   localparam logic [31:0] LOAD_LAST = 32'(LOAD_CYC - 1);

   assign sel_now = {cfg_pick_hi_in, cfg_pick_lo_in};

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_st = st;
      next_strap = strap;
      next_samp = samp;
      next_tmr = tmr;
      next_quiet_done = quiet_done;
      next_sel_seen = sel_seen;
      next_load = load;
      next_pulse = 1'b0;
      // one timer for both waits; a select change load only starts once quiet is done
      if (!quiet_done) begin
         if (tmr >= QUIET_LAST)
            next_quiet_done = 1'b1;
         else
            next_tmr = tmr + 32'h1;
      end
      unique case (st)
         ST_STRAP: begin
            // the pin is released here, so pull resistors set its level
            // a few cycles of settle, then one capture
            if (samp == 3'(csr_pkg::STRAP_SAMPLE_CYC - 1)) begin
               next_strap = refout_strap_pin_in;
               next_st = ST_BOOT;
            end else begin
               next_samp = samp + 3'h1;
            end
         end
         ST_BOOT: begin
            // boot load takes the pins as they stand after capture
            next_pulse = 1'b1;
            next_sel_seen = sel_now;
            if (strap) begin
               next_load.i2c_dflt = 1'b0;
               next_load.cfg = sel_now;
            end else begin
               next_load.i2c_dflt = i2c_default_load_bit_in;
               next_load.cfg = csr_pkg::CFG_ZERO;
            end
            next_st = ST_RUN;
         end
         ST_RUN: begin
            // changes inside a load window are caught here on return
            // late select changes only
            if (strap && quiet_done && !i2c_default_load_bit_in &&
                sel_now != sel_seen) begin
               next_sel_seen = sel_now;
               next_load.cfg = sel_now;
               next_tmr = '0;
               next_st = ST_LOAD;
            end
         end
         ST_LOAD: begin
            // load applied inside 1 ms
            // pulse once at the start; the window is the busy time
            if (tmr == 32'h0)
               next_pulse = 1'b1;
            if (tmr >= LOAD_LAST)
               next_st = ST_RUN;
            else
               next_tmr = tmr + 32'h1;
         end
      endcase
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         st <= ST_STRAP;
         strap <= 1'b0;
         samp <= '0;
         tmr <= '0;
         quiet_done <= 1'b0;
         sel_seen <= '0;
         load <= '0;
         pulse <= 1'b0;
      end else begin
         st <= next_st;
         strap <= next_strap;
         samp <= next_samp;
         tmr <= next_tmr;
         quiet_done <= next_quiet_done;
         sel_seen <= next_sel_seen;
         load <= next_load;
         pulse <= next_pulse;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_prim_reg = prim_reg;
      if (reg_wr_in.wr && !strap && st != ST_STRAP &&
          reg_wr_in.addr == csr_pkg::REG_PRIM_ADDR)
         next_prim_reg = reg_wr_in.data;
      // read data registered, one cycle after the address
      next_rd_data = (reg_rd_addr_in == csr_pkg::REG_PRIM_ADDR) ?
                     prim_reg : 8'h00;
      // spread to dividers, range is left to software
      next_spread = spread_amount_in;
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         prim_reg <= csr_pkg::PRIM_RESET;
         rd_data <= 8'h00;
         spread <= '0;
      end else begin
         prim_reg <= next_prim_reg;
         rd_data <= next_rd_data;
         spread <= next_spread;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // source follows register bit 1 and the pick pin
   csr_ref_mux u_mux (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .primary_source_bit_in(prim_reg[csr_pkg::PRIM_BIT]),
      .input_pick_pin_in(input_pick_pin_in),
      .switchover_mode_field_in(switchover_mode_field_in),
      .src_out(ref_src_out)
   );

   ////////////////////////////////////////////////////////////////////////
   assign strap_done_out = (st != ST_STRAP);
   // plain pass-through, no retiming, keeps the reference edges clean
   // pin turns to ref output
   assign refout_strap_pin_oe_n_out = (st == ST_STRAP);
   assign refout_strap_pin_out = (st == ST_STRAP) ? 1'b0 : refclk_in;
   assign i2c_enable_out = strap_done_out && !strap;
   assign sel_pins_enable_out = strap_done_out && strap;
   assign load_out = load;
   assign load_pulse_out = pulse;
   // busy through strap, boot and the load window
   assign loading_out = (st == ST_LOAD) || (st == ST_STRAP) || (st == ST_BOOT);
   assign reg_rd_data_out = rd_data;
   assign fod_spread_out = spread;
endmodule : csr_top

// File: rtl/csr_pkg.sv
// package for the configuration select and reference pick block
// assumes one 250 MHz clock and an internal register port for 0x13
package csr_pkg;
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned SEL_QUIET_MS = 10;
   localparam int unsigned SEL_QUIET_CYC = SEL_QUIET_MS * 1000 * CLK_MHZ;
   localparam int unsigned LOAD_US = 1000;
   // longest time rounds down
   localparam int unsigned LOAD_CYC = LOAD_US * CLK_MHZ;
   localparam logic [7:0] REG_PRIM_ADDR = 8'h13;
   localparam int unsigned PRIM_BIT = 1;
   localparam logic [7:0] PRIM_RESET = 8'h00;
   localparam int unsigned SM_HI_BIT = 1;
   localparam logic [1:0] CFG_ZERO = 2'h0;
   localparam int unsigned STRAP_SAMPLE_CYC = 4;
   localparam int unsigned SPREAD_W = 8;

   typedef enum logic [1:0] {
      CSR_SRC_CRYSTAL,
      CSR_SRC_DIFF
   } csr_src_t;

   typedef struct packed {
      logic i2c_dflt;
      logic [1:0] cfg;
   } csr_load_t;

   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } csr_reg_wr_t;
endpackage : csr_pkg

// File: rtl/csr_ref_mux.sv
// reference input selector for manual switchover
// assumes both reference clocks are already sampled as levels
`timescale 1ns/1ps
module csr_ref_mux (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic primary_source_bit_in,
   input wire logic input_pick_pin_in,
   input wire logic [1:0] switchover_mode_field_in,
   output csr_pkg::csr_src_t src_out
);
   csr_pkg::csr_src_t src;
   csr_pkg::csr_src_t next_src;

   always_comb begin
      next_src = src;
      if (!switchover_mode_field_in[csr_pkg::SM_HI_BIT]) begin
         if (primary_source_bit_in ^ input_pick_pin_in)
            next_src = csr_pkg::CSR_SRC_DIFF;
         else
            next_src = csr_pkg::CSR_SRC_CRYSTAL;
      end
   end

   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in)
         src <= csr_pkg::CSR_SRC_CRYSTAL;
      else
         src <= next_src;
   end

   assign src_out = src;
endmodule : csr_ref_mux

// File: dv/csr_board.sv
// board controller model: strap level, select pins, reference clock
// assumes the bench sets the target pins; it moves one pin per step
`timescale 1ns/1ps
module csr_board #(parameter int unsigned GAP = 30) (
   input wire logic mclk_in,
   input wire logic [1:0] target_in,
   input wire logic strap_up_in,
   input wire logic oe_n_in,
   input wire logic drive_in,
   output logic pin_out,
   output logic refclk_out,
   output logic [1:0] sel_out
);
   int unsigned gap_cnt = 0;
   // pins are at a level from power-up
   initial sel_out = 2'h2;
   initial refclk_out = 1'b0;
   // strap level while released, device level once driving
   assign pin_out = oe_n_in ? strap_up_in : drive_in;
   always @(posedge mclk_in) begin
      refclk_out <= !refclk_out;
      // one pin per step, quiet gap after it
      if (gap_cnt != 0) begin
         gap_cnt <= gap_cnt - 1;
      end else if (sel_out != target_in) begin
         gap_cnt <= GAP;
         if (sel_out[1] != target_in[1]) sel_out[1] <= target_in[1];
         else sel_out[0] <= target_in[0];
      end
   end
endmodule : csr_board

// File: dv/csr_top_chk.sv
// checker of the csr_top ports
// bound to every csr_top; counts handed on from the instance
`timescale 1ns/1ps
module csr_top_chk #(
   parameter int unsigned SEL_QUIET_CYC = 100,
   parameter int unsigned LOAD_CYC = 20
) (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic refout_strap_pin_out,
   input wire logic refout_strap_pin_oe_n_out,
   input wire logic refclk_in,
   input wire logic cfg_pick_hi_in,
   input wire logic cfg_pick_lo_in,
   input wire logic i2c_default_load_bit_in,
   input wire logic [1:0] switchover_mode_field_in,
   input wire logic strap_done_out,
   input wire logic i2c_enable_out,
   input wire logic sel_pins_enable_out,
   input wire csr_pkg::csr_load_t load_out,
   input wire logic load_pulse_out,
   input wire logic loading_out,
   input wire csr_pkg::csr_src_t ref_src_out
);
   localparam int LW = LOAD_CYC + 8;
   logic [31:0] age;
   // saturates so a long run never wraps back into the quiet time
   always_ff @(posedge mclk_in or posedge sys_rst_in) begin
      if (sys_rst_in) age <= 32'h0;
      else if (age != 32'hFFFFFFFF) age <= age + 32'h1;
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (sys_rst_in);
   chk_oe_strap: assert property (!strap_done_out |->
      refout_strap_pin_oe_n_out) else $error("strap pin driven early");
   chk_ref_out: assert property (strap_done_out |->
      !refout_strap_pin_oe_n_out && refout_strap_pin_out == refclk_in)
      else $error("reference not on strap pin");
   chk_mode_excl: assert property (strap_done_out |->
      i2c_enable_out != sel_pins_enable_out) else $error("pin mode");
   chk_strap_keep: assert property (strap_done_out |=>
      strap_done_out && $stable(i2c_enable_out)) else $error("strap lost");
   chk_sel_load: assert property (load_pulse_out && sel_pins_enable_out
      |-> load_out.cfg == {cfg_pick_hi_in, cfg_pick_lo_in})
      else $error("wrong select config");
   chk_i2c_load: assert property (load_pulse_out && i2c_enable_out |->
      load_out == {i2c_default_load_bit_in, 2'h0}) else $error("i2c load");
   chk_sel_gate: assert property (load_pulse_out && age > 8 |->
      sel_pins_enable_out && !i2c_default_load_bit_in
      && age > SEL_QUIET_CYC) else $error("select change taken");
   chk_load_win: assert property (load_pulse_out && age > 8 |->
      loading_out ##[1:LW] !loading_out) else $error("load window");
   chk_mux_hold: assert property (switchover_mode_field_in[1] &&
      $past(switchover_mode_field_in[1]) |=> $stable(ref_src_out))
      else $error("source moved in auto mode");
   cov_sel: cover property (load_pulse_out && sel_pins_enable_out);
   cov_i2c: cover property (load_pulse_out && i2c_enable_out);
   cov_src: cover property ($changed(ref_src_out));
endmodule : csr_top_chk
bind csr_top csr_top_chk #(.SEL_QUIET_CYC(SEL_QUIET_CYC),
   .LOAD_CYC(LOAD_CYC)) u_chk (.*);

// File: dv/test_config_select_and_refclk_mux.sv
// bench: strap high select run, then strap low i2c run
// assumes short quiet and load counts and the board model
`timescale 1ns/1ps
module test_config_select_and_refclk_mux;
   logic mclk = 1'b0, rst = 1'b1, up = 1'b1, ibit = 1'b0, pick = 1'b0;
   logic [1:0] mode = 2'h0, tgt = 2'h2;
   logic [7:0] rd_addr = 8'h00, spread = 8'h00, rd_data, fod, d;
   csr_pkg::csr_reg_wr_t wr = '0;
   csr_pkg::csr_load_t load;
   csr_pkg::csr_src_t src, held;
   logic pin, pin_o, oe_n, refclk, hi, lo, done, i2c_en, sel_en;
   logic pulse, loading;
   int n_fail = 0, comparisons = 0, seed = 16995, i;
   always #2 mclk = ~mclk;
   csr_board #(.GAP(30)) u_board (.mclk_in(mclk), .target_in(tgt),
      .strap_up_in(up), .oe_n_in(oe_n), .drive_in(pin_o), .pin_out(pin),
      .refclk_out(refclk), .sel_out({hi, lo}));
   csr_top #(.SEL_QUIET_CYC(100), .LOAD_CYC(20)) dut (.mclk_in(mclk),
      .sys_rst_in(rst), .refout_strap_pin_in(pin),
      .refout_strap_pin_out(pin_o), .refout_strap_pin_oe_n_out(oe_n),
      .refclk_in(refclk), .cfg_pick_hi_in(hi), .cfg_pick_lo_in(lo),
      .i2c_default_load_bit_in(ibit), .input_pick_pin_in(pick),
      .switchover_mode_field_in(mode), .reg_wr_in(wr),
      .reg_rd_addr_in(rd_addr), .reg_rd_data_out(rd_data),
      .spread_amount_in(spread), .fod_spread_out(fod),
      .strap_done_out(done), .i2c_enable_out(i2c_en),
      .sel_pins_enable_out(sel_en), .load_out(load),
      .load_pulse_out(pulse), .loading_out(loading), .ref_src_out(src));
   function automatic csr_pkg::csr_src_t exp_src(logic p, logic k);
      return (p ^ k) ? csr_pkg::CSR_SRC_DIFF : csr_pkg::CSR_SRC_CRYSTAL;
   endfunction : exp_src
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report
   task automatic chk(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("MISMATCH t=%0t %s", $time, msg);
      end
   endtask : chk
   task automatic tk(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tk
   task automatic reset_dut(input logic s);
      @(posedge mclk);
      rst <= 1'b1;
      up <= s;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      tk(8);
   endtask : reset_dut
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk);
      wr <= '{1'b1, a, v};
      @(posedge mclk);
      wr.wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk);
      rd_addr <= a;
      tk(1);
      chk(rd_data === v, "register read");
   endtask : rd_reg
   task automatic wait_load(input logic [1:0] v);
      for (i = 0; i < 400 && pulse !== 1'b1; i++) tk(1);
      if (i == 400) begin
         chk(1'b0, "load timeout");
         final_report();
      end else begin
         chk(load.cfg === v && loading === 1'b1, "loaded config");
         tk(1);
      end
   endtask : wait_load
   initial begin
      reset_dut(1'b1);
      chk(done === 1'b1, "strap done");
      chk(sel_en === 1'b1 && i2c_en === 1'b0, "select mode");
      chk(load.cfg === 2'h2, "boot config");
      chk(oe_n === 1'b0 && pin === refclk, "reference out");
      wr_reg(8'h13, 8'h02);
      rd_reg(8'h13, 8'h00);
      tgt <= 2'h3;
      tk(20);
      chk(load.cfg === 2'h2, "early select ignored");
      wait_load(2'h3);
      tgt <= 2'h1;
      wait_load(2'h1);
      tgt <= 2'h0;
      wait_load(2'h0);
      $display("test select_mode done");
      @(posedge mclk);
      ibit <= 1'($random(seed));
      reset_dut(1'b0);
      chk(i2c_en === 1'b1 && sel_en === 1'b0, "i2c mode");
      chk(load === {ibit, 2'h0}, "i2c boot load");
      tgt <= 2'h3;
      tk(150);
      chk(load === {ibit, 2'h0}, "select ignored");
      d = 8'($random(seed));
      wr_reg(8'h13, d);
      rd_reg(8'h13, d);
      rd_reg(8'h55, 8'h00);
      for (int k = 0; k < 4; k++) begin
         wr_reg(8'h13, {6'h00, k[1], 1'b0});
         pick <= k[0];
         tk(3);
         chk(src === exp_src(k[1], k[0]), "source pick");
      end
      held = src;
      @(posedge mclk);
      mode <= 2'h2;
      pick <= ~pick;
      tk(3);
      chk(src === held, "source held");
      @(posedge mclk);
      spread <= d;
      tk(2);
      chk(fod === d, "spread amount");
      $display("test i2c_mode done");
      final_report();
   end
endmodule : test_config_select_and_refclk_mux
